// File: src/serial_lane_retimer.sv
// Contract
// - at most two retimers between end nodes
// - regain boundaries, resend on local timing
// - no protocol awareness, no addressable state
// - insert at most one skip after commas
// - delete one skip only after commas
// - skip is disparity neutral, no correction
// - four lanes synced and deskewed like ports
// - keep working on lane 0 or 2 alone
// - forward remaining active lanes on dropout
// - optionally disable outputs of inactive lanes
// - skip insert/delete always a full column
// - both sides run the same link width
// - compensate receive versus transmit clock tolerance
// - no code checks, forward code-groups unchanged
// - sync after 127 commas without invalid
// - deskew on align columns, up to seven
`include "retimer_map.svh"

module serial_lane_retimer
    import retimer_pkg::*;
#(
    parameter int LANES = 4, // one width on both sides
    parameter int AW = `RT_BUF_AW,
    parameter int FILL_LOW = `RT_FILL_LOW,
    parameter int FILL_HIGH = `RT_FILL_HIGH,
    parameter int MAX_SKEW = `RT_MAX_SKEW
) (
    input wire logic clock, // local reference clock
    input wire logic rstn, // async reset, active low
    input wire logic [LANES-1:0] rx_valid, // code-group strobe per lane
    input wire logic [LANES-1:0][7:0] rx_data, // decoded byte per lane
    input wire logic [LANES-1:0] rx_is_k, // control code-group flag
    input wire logic [LANES-1:0] rx_invalid, // decoder saw an invalid group
    input wire logic [LANES-1:0] signal_detect, // receiver sees a signal
    input wire logic tx_tick, // one column due for transmission
    output logic tx_valid, // column presented on this tick
    output logic [LANES-1:0][7:0] tx_data, // byte per lane
    output logic [LANES-1:0] tx_is_k, // control flag per lane
    output logic [LANES-1:0] tx_oe, // lane driver enable
    output logic [LANES-1:0] lane_sync // lane is in code-group sync
);
    localparam logic [AW:0] FILL_LOW_C = (AW+1)'(FILL_LOW);
    localparam logic [AW:0] FILL_HIGH_C = (AW+1)'(FILL_HIGH);
    localparam logic [AW:0] DEPTH_C = (AW+1)'(2**AW);
    localparam logic [3:0] SKEW_C = 4'(MAX_SKEW);

    logic [LANES-1:0] pop; // column logic consumes the head of a lane
    logic [LANES-1:0] head_ok; // registered head matches the read pointer
    code_t head [LANES]; // head code-group of each lane buffer
    logic [AW:0] fill [LANES]; // entries held per lane

    genvar i;
    generate
        for (i = 0; i < LANES; i++)
        begin : g_lane
            sync_state_e st;
            sync_state_e next_st;
            logic [6:0] kcnt;
            logic [6:0] next_kcnt;
            logic [2:0] icnt;
            logic [2:0] next_icnt;
            logic [3:0] vcnt;
            logic [3:0] next_vcnt;
            logic [AW:0] wr_ptr;
            logic [AW:0] next_wr_ptr;
            logic [AW:0] rd_ptr;
            logic [AW:0] next_rd_ptr;
            logic next_ok;
            logic wr_en;
            logic comma;

            assign comma = rx_is_k[i] && (rx_data[i] == `RT_CG_COMMA);

            // synchroniser: counters give hysteresis against bit errors
            always_comb
            begin
                next_st = st;
                next_kcnt = kcnt;
                next_icnt = icnt;
                next_vcnt = vcnt;
                if (!signal_detect[i])
                begin
                    next_st = st_no_sync;
                end
                else if (rx_valid[i])
                begin
                    case (st)
                        st_no_sync:
                        begin
                            if (comma)
                            begin
                                next_st = st_count;
                                next_kcnt = 7'h00;
                            end
                        end
                        st_count:
                        begin
                            if (rx_invalid[i])
                            begin
                                next_st = st_no_sync;
                            end
                            else if (comma && kcnt == 7'(`RT_SYNC_COMMAS - 1))
                            begin
                                next_st = st_sync;
                                next_icnt = 3'h0;
                                next_vcnt = 4'h0;
                            end
                            else if (comma)
                            begin
                                next_kcnt = kcnt + 7'h01;
                            end
                        end
                        st_sync:
                        begin
                            if (rx_invalid[i])
                            begin
                                next_vcnt = 4'h0;
                                next_icnt = icnt + 3'h1;
                                if (icnt == 3'(`RT_LOSS_INVALID - 1))
                                begin
                                    next_st = st_no_sync;
                                end
                            end
                            else if (icnt != 3'h0)
                            begin
                                // a long clean run forgives one earlier error
                                next_vcnt = vcnt + 4'h1;
                                if (vcnt == 4'(`RT_VALID_FORGIVE - 1))
                                begin
                                    next_vcnt = 4'h0;
                                    next_icnt = icnt - 3'h1;
                                end
                            end
                        end
                        default:
                        begin
                            next_st = st_no_sync;
                        end
                    endcase
                end
            end

            // buffer pointers; a full buffer drops the incoming group
            assign wr_en = rx_valid[i] && (st == st_sync) && (fill[i] != DEPTH_C);
            assign fill[i] = wr_ptr - rd_ptr;

            always_comb
            begin
                next_wr_ptr = wr_ptr + (AW+1)'(wr_en);
                next_rd_ptr = rd_ptr + (AW+1)'(pop[i]);
                if (st != st_sync)
                begin
                    next_rd_ptr = wr_ptr; // flush a lane out of sync
                end
                // head is good next cycle only if the slot was written earlier
                next_ok = !pop[i] && (fill[i] != '0) && (st == st_sync);
            end

            always_ff @(posedge clock or negedge rstn)
            begin
                if (!rstn)
                begin
                    st <= st_no_sync;
                    kcnt <= 7'h00;
                    icnt <= 3'h0;
                    vcnt <= 4'h0;
                    wr_ptr <= '0;
                    rd_ptr <= '0;
                    head_ok[i] <= 1'b0;
                    lane_sync[i] <= 1'b0;
                end
                else
                begin
                    st <= next_st;
                    kcnt <= next_kcnt;
                    icnt <= next_icnt;
                    vcnt <= next_vcnt;
                    wr_ptr <= next_wr_ptr;
                    rd_ptr <= next_rd_ptr;
                    head_ok[i] <= next_ok;
                    lane_sync[i] <= (next_st == st_sync);
                end
            end

            // code-groups stored untouched, errors included
            lane_elastic_mem #(
                .W(9),
                .AW(AW)
            ) u_mem (
                .clock(clock),
                .rstn(rstn),
                .wr_en(wr_en),
                .wr_addr(wr_ptr[AW-1:0]),
                .wr_data({rx_is_k[i], rx_data[i]}),
                .rd_addr(rd_ptr[AW-1:0]),
                .rd_data(head[i])
            );
        end
    endgenerate

    // column classification: only commas, skips and align groups are seen
    logic [LANES-1:0] act; // lanes in sync take part in the column
    logic [LANES-1:0] is_k; // head is a comma
    logic [LANES-1:0] is_a; // head is an align group
    logic [LANES-1:0] is_r; // head is a skip
    logic all_ok; // every active head ready
    logic col_k; // full comma column
    logic col_a; // full align column
    logic col_r; // full skip column
    logic some_a; // at least one align, skew suspected
    logic [AW:0] ref_fill; // fill of the lowest active lane

    always_comb
    begin
        act = lane_sync;
        for (int n = 0; n < LANES; n++)
        begin
            is_k[n] = head[n][8] && (head[n][7:0] == `RT_CG_COMMA);
            is_a[n] = head[n][8] && (head[n][7:0] == `RT_CG_ALIGN);
            is_r[n] = head[n][8] && (head[n][7:0] == `RT_CG_SKIP);
        end
        all_ok = (act != '0) && ((head_ok | ~act) == '1);
        col_k = all_ok && ((is_k | ~act) == '1);
        col_a = all_ok && ((is_a | ~act) == '1);
        col_r = all_ok && ((is_r | ~act) == '1);
        some_a = all_ok && ((is_a & act) != '0);
        // lane 0 alone, lane 2 alone or all four give a reference
        ref_fill = '0;
        for (int n = LANES - 1; n >= 0; n--)
        begin
            if (act[n])
            begin
                ref_fill = fill[n];
            end
        end
    end

    // column engine state
    logic last_k; // last sent column was commas and no skip has been added or dropped since
    logic next_last_k;
    logic [3:0] skew_cnt; // groups dropped while deskewing
    logic [3:0] next_skew_cnt;
    logic next_tx_valid;
    logic [LANES-1:0][7:0] next_tx_data;
    logic [LANES-1:0] next_tx_is_k;

    // one column per tick; drops and deskew use the idle cycles between ticks
    always_comb
    begin
        pop = '0;
        next_last_k = last_k;
        next_skew_cnt = skew_cnt;
        next_tx_valid = 1'b0;
        next_tx_data = tx_data;
        next_tx_is_k = tx_is_k;
        if (tx_tick)
        begin
            if (last_k && (act != '0) && (ref_fill < FILL_LOW_C))
            begin
                // running dry: one skip column, disparity is untouched
                next_tx_valid = 1'b1;
                next_last_k = 1'b0; // one skip per comma run keeps a chain legal
                for (int n = 0; n < LANES; n++)
                begin
                    next_tx_data[n] = act[n] ? `RT_CG_SKIP : 8'h00;
                    next_tx_is_k[n] = act[n];
                end
            end
            else if (all_ok)
            begin
                next_tx_valid = 1'b1;
                pop = act;
                next_last_k = col_k;
                for (int n = 0; n < LANES; n++)
                begin
                    next_tx_data[n] = act[n] ? head[n][7:0] : 8'h00;
                    next_tx_is_k[n] = act[n] && head[n][8];
                end
            end
        end
        else if (all_ok)
        begin
            if (last_k && col_r && (ref_fill > FILL_HIGH_C))
            begin
                pop = act;
                next_last_k = 1'b0;
            end
            else if (some_a && !col_a && (skew_cnt < SKEW_C))
            begin
                // early lanes wait on their align group; late idles dropped
                pop = act & ~is_a;
                next_skew_cnt = skew_cnt + 4'h1;
            end
        end
        if (!some_a || col_a)
        begin
            next_skew_cnt = 4'h0;
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            last_k <= 1'b0;
            skew_cnt <= 4'h0;
            tx_valid <= 1'b0;
            tx_data <= '0;
            tx_is_k <= '0;
            tx_oe <= '0;
        end
        else
        begin
            last_k <= next_last_k;
            skew_cnt <= next_skew_cnt;
            tx_valid <= next_tx_valid;
            tx_data <= next_tx_data;
            tx_is_k <= next_tx_is_k;
            tx_oe <= lane_sync;
        end
    end
endmodule

// File: src/retimer_map.svh
`ifndef RETIMER_MAP_SVH
`define RETIMER_MAP_SVH

// decoded data value of the special code-groups (control flag set)
`define RT_CG_COMMA 8'hbc
`define RT_CG_ALIGN 8'h7c
`define RT_CG_SKIP 8'hfd

// commas needed after the first one before a lane counts as in sync
`define RT_SYNC_COMMAS 127
// invalid code-groups in sync before the lane is dropped
`define RT_LOSS_INVALID 4
// valid code-groups that forgive one earlier invalid one
`define RT_VALID_FORGIVE 15
// largest lane skew corrected, in code-group times
`define RT_MAX_SKEW 7

// elastic buffer geometry and fill thresholds
`define RT_BUF_AW 4
`define RT_FILL_LOW 4
`define RT_FILL_HIGH 12

`endif

// File: src/retimer_pkg.sv
package retimer_pkg;
    // per-lane code-group synchroniser states
    typedef enum logic [2:0]
    {
        st_no_sync = 3'b001,
        st_count = 3'b010,
        st_sync = 3'b100
    } sync_state_e;

    // one forwarded code-group: control flag over data byte
    typedef logic [8:0] code_t;
endpackage

// File: src/lane_elastic_mem.sv
module lane_elastic_mem #(
    parameter int W = 9,
    parameter int AW = 4
) (
    input wire logic clock, // local reference clock
    input wire logic rstn, // async reset, active low
    input wire logic wr_en, // write strobe
    input wire logic [AW-1:0] wr_addr, // write slot
    input wire logic [W-1:0] wr_data, // code-group written
    input wire logic [AW-1:0] rd_addr, // read slot
    output logic [W-1:0] rd_data // registered read data
);
    // storage, no reset needed: slots are only read after being written
    logic [W-1:0] mem [2**AW];

    // write port
    always_ff @(posedge clock)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
    end

    // read port, one cycle latency
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            rd_data <= '0;
        end
        else
        begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule

// File: test/serial_lane_retimer_monitor.sv
`include "retimer_map.svh"

module serial_lane_retimer_monitor
    import retimer_pkg::*;
#(
    parameter int LANES = 4
) (
    input wire logic clock, // local reference clock
    input wire logic rstn, // async reset, active low
    input wire logic [LANES-1:0] rx_valid, // group strobe
    input wire logic [LANES-1:0][7:0] rx_data, // decoded byte
    input wire logic [LANES-1:0] rx_is_k, // control flag
    input wire logic [LANES-1:0] rx_invalid, // decoder error
    input wire logic [LANES-1:0] signal_detect, // signal present
    input wire logic tx_tick, // column due
    input wire logic tx_valid, // column sent
    input wire logic [LANES-1:0][7:0] tx_data, // sent bytes
    input wire logic [LANES-1:0] tx_is_k, // sent flags
    input wire logic [LANES-1:0] tx_oe, // driver enables
    input wire logic [LANES-1:0] lane_sync // lanes in sync
);
    timeunit 1ns;
    timeprecision 1ns;

    // one domain, so clock and reset are given once
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    // a column only ever answers a tick, and only one cycle wide
    a_valid_after_tick: assert property (tx_valid |-> $past(tx_tick))
        else $error("column sent without a tick");
    a_valid_single: assert property (tx_valid |=> !tx_valid)
        else $error("column strobe longer than one cycle");
    // drivers trail the sync flags by exactly one cycle
    a_oe_follows_sync: assert property (tx_oe == $past(lane_sync))
        else $error("driver enable not lane sync delayed");
    // nothing to send when no lane was active at the tick
    a_no_lane_no_col: assert property (tx_valid |-> $past(|lane_sync))
        else $error("column sent with no lane in sync");

    // per-lane relations; lanes are independent so each gets its own copy
    for (genvar i = 0; i < LANES; i++)
    begin : g_lane
        a_sync_needs_sd: assert property (!signal_detect[i] |=> !lane_sync[i])
            else $error("lane kept sync with no signal");
        a_sync_rise_comma: assert property ($rose(lane_sync[i]) |-> $past(rx_valid[i]
            && rx_is_k[i] && rx_data[i] == `RT_CG_COMMA && !rx_invalid[i]))
            else $error("sync gained on something other than a comma");
        a_sync_fall_cause: assert property ($fell(lane_sync[i]) |->
            $past((rx_valid[i] && rx_invalid[i]) || !signal_detect[i]))
            else $error("sync lost without error or signal loss");
        // a lane idle on both sides of the tick must not leak old bytes
        a_idle_lane_zero: assert property (tx_valid && !lane_sync[i]
            && !$past(lane_sync[i]) |-> tx_data[i] == 8'h00)
            else $error("inactive lane carried data");
    end

    // main scenarios reached
    c_all_sync: cover property ($rose(&lane_sync));
    c_skip_col: cover property (tx_valid && tx_data == {LANES{`RT_CG_SKIP}});
    c_partial: cover property (tx_valid && lane_sync != '1 && lane_sync != '0);
endmodule

bind serial_lane_retimer serial_lane_retimer_monitor #(.LANES(LANES)) u_mon (
    .clock(clock), .rstn(rstn), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_is_k(rx_is_k), .rx_invalid(rx_invalid), .signal_detect(signal_detect),
    .tx_tick(tx_tick), .tx_valid(tx_valid), .tx_data(tx_data), .tx_is_k(tx_is_k),
    .tx_oe(tx_oe), .lane_sync(lane_sync)
);

// File: test/link_port_model.sv
module link_port_model
    import retimer_pkg::*;
#(
    parameter int LANES = 4 // same width as the retimer
) (
    input wire logic clock, // local reference clock
    output logic [LANES-1:0] rx_valid, // group strobe
    output logic [LANES-1:0][7:0] rx_data, // decoded byte
    output logic [LANES-1:0] rx_is_k, // control flag
    output logic [LANES-1:0] rx_invalid // decoder error flag
);
    timeunit 1ns;
    timeprecision 1ns;

    // quiet link at time zero
    initial
    begin
        rx_valid = '0;
        rx_data = '0;
        rx_is_k = '0;
        rx_invalid = '0;
    end

    // one column per call; skew is mimicked by the lane mask
    task automatic send(input logic [LANES-1:0] m, input logic [LANES-1:0][7:0] d,
        input logic [LANES-1:0] k, input logic [LANES-1:0] inv);
        @(posedge clock);
        #1 rx_valid = m;
        rx_data = d;
        rx_is_k = k;
        rx_invalid = inv;
    endtask

    // released lines flip so a stale byte never looks like a fresh one
    task automatic idle;
        @(posedge clock);
        #1 rx_valid = '0;
        rx_data = ~rx_data;
        rx_is_k = ~rx_is_k;
    endtask
endmodule

// File: test/serial_lane_retimer_bench.sv
`include "retimer_map.svh"

module serial_lane_retimer_bench
    import retimer_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;

    localparam int LANES = 4; // full-width retimer
    logic clock = 1'b0; // 10 MHz reference
    logic rstn = 1'b0; // held low at start
    logic [LANES-1:0] rx_valid; // from far port
    logic [LANES-1:0][7:0] rx_data; // from far port
    logic [LANES-1:0] rx_is_k; // from far port
    logic [LANES-1:0] rx_invalid; // from far port
    logic [LANES-1:0] signal_detect = '1; // all receivers lit
    logic tx_tick = 1'b0; // column request
    logic tx_valid; // column sent
    logic [LANES-1:0][7:0] tx_data; // sent bytes
    logic [LANES-1:0] tx_is_k; // sent flags
    logic [LANES-1:0] tx_oe; // driver enables
    logic [LANES-1:0] lane_sync; // sync flags
    int error_cnt = 0; // mismatches
    int n_compared = 0; // comparisons

    // half period of 50 ns
    always #50 clock = ~clock;

    link_port_model #(.LANES(LANES)) u_far (.clock(clock), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_is_k(rx_is_k), .rx_invalid(rx_invalid));

    serial_lane_retimer #(.LANES(LANES)) u_dut (.clock(clock), .rstn(rstn),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_is_k(rx_is_k),
        .rx_invalid(rx_invalid), .signal_detect(signal_detect), .tx_tick(tx_tick),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_is_k(tx_is_k), .tx_oe(tx_oe),
        .lane_sync(lane_sync));

    // compare and count; unknowns match only unknowns in the same bits
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic conclude;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // n comma columns on every lane
    task automatic commas(input int n);
        repeat (n) u_far.send('1, {LANES{`RT_CG_COMMA}}, '1, '0);
    endtask

    // one tick, then an idle cycle so the heads are ready again
    task automatic tick(output logic v, output logic [31:0] c, output logic [3:0] k);
        @(posedge clock);
        #1 tx_tick = 1'b1;
        @(posedge clock);
        #1 tx_tick = 1'b0;
        v = tx_valid;
        c = tx_data;
        k = tx_is_k;
        @(posedge clock);
    endtask

    task automatic expect_col(input logic ev, input logic [31:0] ec, input logic [3:0] ek);
        logic v;
        logic [31:0] c;
        logic [3:0] k;
        tick(v, c, k);
        check({3'h0, v, k, c}, {3'h0, ev, ek, ec});
    endtask

    // lane 3 restarts after an invalid group, others sync at comma 128
    task automatic t_sync;
        logic v;
        logic [31:0] c;
        logic [3:0] k;
        int miss;
        miss = 0;
        commas(40);
        u_far.send('1, {LANES{`RT_CG_COMMA}}, '1, 4'h8);
        commas(86);
        u_far.idle();
        check(40'(lane_sync), 40'h0);
        commas(1);
        u_far.idle();
        check(40'(lane_sync), 40'h7);
        // lane 3 has seen 87 commas since its restart; 40 more leave it one short
        commas(40);
        u_far.idle();
        check(40'(lane_sync), 40'h7);
        commas(1);
        u_far.idle();
        check(40'(lane_sync), 40'hf);
        // top every buffer up to full, then drain until ticks go unanswered
        commas(20);
        u_far.idle();
        for (int n = 0; n < 80 && miss < 3; n++)
        begin
            tick(v, c, k);
            miss = v ? 0 : miss + 1;
        end
    endtask

    // one skip column after a comma column, bad groups forwarded as they came
    task automatic t_comp;
        u_far.send('1, 32'h13121110, '0, '0);
        commas(1);
        u_far.send('1, 32'h23222120, '0, 4'h2);
        u_far.send('1, 32'h33323130, 4'h4, '0);
        u_far.idle();
        expect_col(1'b1, 32'h13121110, 4'h0);
        expect_col(1'b1, {LANES{`RT_CG_COMMA}}, 4'hf);
        expect_col(1'b1, {LANES{`RT_CG_SKIP}}, 4'hf);
        expect_col(1'b1, 32'h23222120, 4'h0);
        expect_col(1'b1, 32'h33323130, 4'h4);
        expect_col(1'b0, 32'h33323130, 4'h4);
    endtask

    // a skip right after commas is dropped while the buffers run nearly full
    task automatic t_del;
        commas(1);
        u_far.send('1, {LANES{`RT_CG_SKIP}}, '1, '0);
        for (int n = 0; n < 12; n++)
        begin
            u_far.send('1, {LANES{8'(8'h50 + n)}}, '0, '0);
        end
        u_far.idle();
        expect_col(1'b1, {LANES{`RT_CG_COMMA}}, 4'hf);
        // idle edge in which the skip column is dropped, head refills after it
        @(posedge clock);
        for (int n = 0; n < 12; n++)
        begin
            expect_col(1'b1, {LANES{8'(8'h50 + n)}}, 4'h0);
        end
    endtask

    // lane 3 shows its align group one slot early; the others must catch up
    task automatic t_skew;
        u_far.send('1, {`RT_CG_ALIGN, {3{`RT_CG_COMMA}}}, '1, '0);
        u_far.send('1, {8'h73, {3{`RT_CG_ALIGN}}}, 4'h7, '0);
        u_far.send(4'h7, 32'h00727170, '0, '0);
        u_far.idle();
        expect_col(1'b1, {LANES{`RT_CG_ALIGN}}, 4'hf);
        expect_col(1'b1, 32'h73727170, 4'h0);
    endtask

    // fall back to lanes 0 and 2 only
    task automatic t_drop;
        @(posedge clock);
        #1 signal_detect = 4'h5;
        @(posedge clock);
        #1 check(40'(lane_sync), 40'h5);
        @(posedge clock);
        #1 check(40'(tx_oe), 40'h5);
        u_far.send('1, 32'h43424140, '0, '0);
        u_far.idle();
        expect_col(1'b1, 32'h00420040, 4'h0);
    endtask

    // main sequence
    initial
    begin
        repeat (6) @(posedge clock);
        #1 rstn = 1'b1;
        check(40'({tx_valid, tx_oe, lane_sync}), 40'h0);
        t_sync();
        t_comp();
        t_del();
        t_skew();
        t_drop();
        conclude();
    end

    // hang guard, well past the few hundred cycles the run needs
    initial
    begin
        #(3000 * 100);
        error_cnt++;
        conclude();
    end
endmodule
